/* File: tcc_pkg.sv */
package tcc_pkg;

   // Core clock rate
   localparam int CLK_MHZ = 200;

   // Termination debounce time and its cycle count
   localparam int DEBOUNCE_NS  = 10000;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;

   // BMC unit interval and half of it in cycles (rounded down)
   localparam int UI_NS       = 3330;
   localparam int HALF_UI_CYC = (UI_NS * CLK_MHZ) / 2000;

   // Register byte offsets
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_TXLVL  = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_TXDATA = 4'hc;

   // Field widths
   localparam int TXLVL_W = 4;
   localparam int TXDAT_W = 8;

   // Termination seen on one CC line
   typedef enum logic [1:0] {
      TCC_OPEN,
      TCC_RD,
      TCC_RA
   } tcc_term_t;

   // Advertised or detected current capability
   typedef enum logic [1:0] {
      TCC_CUR_DEFAULT,
      TCC_CUR_MEDIUM,
      TCC_CUR_HIGH
   } tcc_cur_t;

   // Comparator outputs of one line
   typedef struct packed {
      logic below_detach;
      logic below_cable;
   } tcc_cmp_t;

   // Control register layout, bit 0 is trim_rd
   typedef struct packed {
      logic     db_rd_off;
      tcc_cur_t adv_cur;
      logic     src_role;
      logic     trim_rd;
   } tcc_ctrl_t;

   // Status register layout
   typedef struct packed {
      tcc_term_t term_b;
      tcc_term_t term_a;
      logic      db_boot_ok;
      logic      tx_busy;
      tcc_cur_t  snk_cur;
      logic      vconn_en_b;
      logic      vconn_en_a;
      logic      vbus_en;
      logic      orient_b;
      logic [2:0] state;
   } tcc_status_t;

   // Values after reset
   localparam tcc_ctrl_t           CTRL_RST  = '0;
   localparam logic [TXLVL_W-1:0]  TXLVL_RST = 4'h8;

   // Termination from the two threshold comparators
   function automatic tcc_term_t tcc_classify(input tcc_cmp_t c);
      if (c.below_cable)
         return TCC_RA;
      else if (c.below_detach)
         return TCC_RD;
      else
         return TCC_OPEN;
   endfunction : tcc_classify

   // Pullup level code from the analog front end to a current
   function automatic tcc_cur_t tcc_level_cur(input logic [1:0] lvl);
      if (lvl == 2'h3)
         return TCC_CUR_HIGH;
      else if (lvl == 2'h2)
         return TCC_CUR_MEDIUM;
      else
         return TCC_CUR_DEFAULT;
   endfunction : tcc_level_cur

endpackage : tcc_pkg

/* File: tcc_sync_filter.sv */
`timescale 1ns/1ps
module tcc_sync_filter #(
   parameter int WIDTH      = 11,
   parameter int STABLE_CYC = tcc_pkg::DEBOUNCE_CYC
) (
   input  wire logic             sys_clk,  // Core clock
   input  wire logic             rst_n,    // Synchronous reset
   input  wire logic [WIDTH-1:0] raw_in,   // Asynchronous levels
   output logic      [WIDTH-1:0] clean     // Synchronised, debounced
);
   import tcc_pkg::*;

   localparam int CW = $clog2(STABLE_CYC + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(STABLE_CYC - 1);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] sync;
   logic [CW-1:0]    cnt;

   // Two-flop synchroniser; meta feeds only sync
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= raw_in;
         sync <= meta;
      end
   end

   // Accept a new value once sync has differed from clean for STABLE_CYC cycles in a row
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt   <= '0;
         clean <= '0;
      end else if (sync == clean) begin
         cnt <= '0;
      end else if (cnt == CNT_LAST) begin
         cnt   <= '0;
         clean <= sync;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

endmodule : tcc_sync_filter

/* File: tcc_bmc_tx.sv */
`timescale 1ns/1ps
module tcc_bmc_tx #(
   parameter int HALF_CYC = tcc_pkg::HALF_UI_CYC
) (
   input  wire logic       sys_clk,  // Core clock
   input  wire logic       rst_n,    // Synchronous reset
   input  wire logic       start,    // Begin one byte
   input  wire logic [7:0] data,     // Byte, sent LSB first
   output logic            busy,     // Byte in flight
   output logic            drive,    // Driver overdrives the line
   output logic            level     // BMC line level
);
   import tcc_pkg::*;

   localparam int HW = $clog2(HALF_CYC + 1);
   localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYC - 1);

   logic [HW-1:0] cnt;
   logic [3:0]    idx;
   logic          phase;
   logic [7:0]    shreg;
   logic          tick;

   assign tick = (cnt == HALF_LAST);
   assign busy = drive;

   // Half-cell timer and bit sequencer
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt   <= '0;
         idx   <= '0;
         phase <= 1'b0;
         shreg <= '0;
         drive <= 1'b0;
         level <= 1'b1;
      end else if (!drive) begin
         if (start) begin
            drive <= 1'b1;
            level <= 1'b0;     // Frame opens low
            cnt   <= '0;
            idx   <= '0;
            phase <= 1'b0;
            shreg <= data;
         end
      end else if (!tick) begin
         cnt <= cnt + 1'b1;
      end else begin
         cnt <= '0;
         if (idx == 4'h8) begin
            drive <= 1'b0;
         end else if (!phase) begin
            phase <= 1'b1;
            if (shreg[0])
               level <= ~level;
         end else begin
            phase <= 1'b0;
            shreg <= shreg >> 1;
            idx   <= idx + 1'b1;
            level <= ~level;
         end
      end
   end

   // Level only moves on half-cell boundaries
   AST_BMC_MID_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (drive && $past(drive) && cnt != '0) |-> $stable(level))
      else $error("BMC level moved inside a half cell");

endmodule : tcc_bmc_tx

/* File: tcc_attach_top.sv */
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module tcc_attach_top (
   input  wire logic          sys_clk,          // 200 MHz core clock
   input  wire logic          rst_n,            // Synchronous reset
   input  wire logic [3:0]    avs_address,      // Byte address
   input  wire logic          avs_read,         // Read request
   input  wire logic          avs_write,        // Write request
   input  wire logic [31:0]   avs_writedata,    // Write data
   output logic      [31:0]   avs_readdata,     // Read data
   output logic               avs_waitrequest,  // Stall master
   input  wire tcc_pkg::tcc_cmp_t cmp_a,        // Line A comparators
   input  wire tcc_pkg::tcc_cmp_t cmp_b,        // Line B comparators
   input  wire logic [1:0]    pullup_lvl_a,     // Sink: level seen on A
   input  wire logic [1:0]    pullup_lvl_b,     // Sink: level seen on B
   input  wire logic          vbus_present,     // VBUS above valid level
   input  wire logic          strap_gnd_a,      // Gate strap A grounded
   input  wire logic          strap_gnd_b,      // Gate strap B grounded
   output logic               cc_pullup_en,     // Pullup current on
   output tcc_pkg::tcc_cur_t  adv_current,      // Advertised level
   output logic               trim_rd_en,       // Trimmed pulldown on
   output logic      [1:0]    db_gate_out,      // Pulldown gate drive
   output logic      [1:0]    db_gate_oe,       // Pulldown gate enable
   output logic               vbus_en,          // Source VBUS switch
   output logic               vconn_en_a,       // VCONN onto line A
   output logic               vconn_en_b,       // VCONN onto line B
   output logic               orient_b,         // Sink line is B
   output logic [tcc_pkg::TXLVL_W-1:0] tx_peak_level, // BMC peak
   output logic               bmc_out,          // BMC data level
   output logic               bmc_oe_a,         // Driver on line A
   output logic               bmc_oe_b          // Driver on line B
);
   import tcc_pkg::*;

   typedef enum logic [2:0] {
      ST_UNATT,
      ST_CABLE,
      ST_ATTACHED,
      ST_DEBUG,
      ST_AUDIO,
      ST_SNK_WAIT,
      ST_SNK_ATT
   } tcc_state_t;

   tcc_ctrl_t   ctrl;
   tcc_state_t  state;
   tcc_state_t  next_state;
   tcc_status_t status;
   tcc_term_t   term_a;
   tcc_term_t   term_b;
   tcc_cur_t    snk_cur;
   logic [10:0] raw_pins;
   logic [10:0] clean;
   tcc_cmp_t    cmp_a_s;
   tcc_cmp_t    cmp_b_s;
   logic [1:0]  lvl_a_s;
   logic [1:0]  lvl_b_s;
   logic        vbus_s;
   logic [1:0]  strap_s;
   logic        cable_b;
   logic        vconn_on;
   logic        next_orient;
   logic        next_cable_b;
   logic        next_vconn;
   logic        db_boot_ok;
   logic        ack;
   logic        hold;
   logic        acc;
   logic        tx_start;
   logic        tx_busy;
   logic        tx_drive;
   logic        linked;

   // All analog and pin levels cross into the core clock here
   assign raw_pins = {cmp_a, cmp_b, pullup_lvl_a, pullup_lvl_b,
                      vbus_present, strap_gnd_a, strap_gnd_b};

   tcc_sync_filter #(
      .WIDTH      (11),
      .STABLE_CYC (DEBOUNCE_CYC)
   ) u_filter (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .raw_in  (raw_pins),
      .clean   (clean)
   );

   assign {cmp_a_s, cmp_b_s, lvl_a_s, lvl_b_s, vbus_s, strap_s} = clean;

   // Each line is judged on its own comparators
   assign term_a = tcc_classify(cmp_a_s);
   assign term_b = tcc_classify(cmp_b_s);

   // Next attach state; the role bit picks the source or sink half
   always_comb begin
      next_state   = state;
      next_orient  = orient_b;
      next_cable_b = cable_b;
      next_vconn   = vconn_on;
      if (ctrl.src_role && (state == ST_SNK_WAIT || state == ST_SNK_ATT)) begin
         next_state = ST_UNATT;
         next_vconn = 1'b0;
      end else if (!ctrl.src_role && !(state == ST_SNK_WAIT
                                       || state == ST_SNK_ATT)) begin
         next_state = ST_SNK_WAIT;
         next_vconn = 1'b0;
      end else begin
         unique case (state)
            ST_UNATT: begin
               next_vconn = 1'b0;
               unique case ({term_a, term_b})
                  {TCC_RD, TCC_OPEN}: begin
                     next_state  = ST_ATTACHED;
                     next_orient = 1'b0;
                  end
                  {TCC_OPEN, TCC_RD}: begin
                     next_state  = ST_ATTACHED;
                     next_orient = 1'b1;
                  end
                  {TCC_RA, TCC_OPEN}: begin
                     next_state   = ST_CABLE;
                     next_cable_b = 1'b0;
                  end
                  {TCC_OPEN, TCC_RA}: begin
                     next_state   = ST_CABLE;
                     next_cable_b = 1'b1;
                  end
                  {TCC_RA, TCC_RD}: begin
                     next_state  = ST_ATTACHED;
                     next_orient = 1'b1;
                     next_vconn  = 1'b1;
                  end
                  {TCC_RD, TCC_RA}: begin
                     next_state  = ST_ATTACHED;
                     next_orient = 1'b0;
                     next_vconn  = 1'b1;
                  end
                  {TCC_RD, TCC_RD}: next_state = ST_DEBUG;
                  {TCC_RA, TCC_RA}: next_state = ST_AUDIO;
                  default:          next_state = ST_UNATT;
               endcase
            end
            ST_CABLE: begin
               // Cable line watched for removal, the other for a sink
               if ((cable_b ? term_b : term_a) == TCC_OPEN) begin
                  next_state = ST_UNATT;
               end else if ((cable_b ? term_a : term_b) == TCC_RD) begin
                  next_state  = ST_ATTACHED;
                  next_orient = ~cable_b;
                  next_vconn  = 1'b1;
               end
            end
            ST_ATTACHED: begin
               // Only the sink line counts; the VCONN line is ignored
               if ((orient_b ? term_b : term_a) == TCC_OPEN) begin
                  next_state = ST_UNATT;
                  next_vconn = 1'b0;
               end
            end
            ST_DEBUG, ST_AUDIO: begin
               if (term_a == TCC_OPEN || term_b == TCC_OPEN)
                  next_state = ST_UNATT;
            end
            ST_SNK_WAIT: begin
               if (vbus_s) begin
                  next_state  = ST_SNK_ATT;
                  next_orient = (lvl_b_s != 2'h0) && (lvl_a_s == 2'h0);
               end
            end
            ST_SNK_ATT: begin
               if (!vbus_s)
                  next_state = ST_SNK_WAIT;
            end
            default: next_state = ST_UNATT;
         endcase
      end
   end

   // Attach state and orientation
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state    <= ST_SNK_WAIT;
         orient_b <= 1'b0;
         cable_b  <= 1'b0;
         vconn_on <= 1'b0;
      end else begin
         state    <= next_state;
         orient_b <= next_orient;
         cable_b  <= next_cable_b;
         vconn_on <= next_vconn;
      end
   end

   // Power switches follow the state one cycle later
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         vbus_en    <= 1'b0;
         vconn_en_a <= 1'b0;
         vconn_en_b <= 1'b0;
      end else begin
         vbus_en    <= (state == ST_ATTACHED);
         vconn_en_a <= (state == ST_ATTACHED) && vconn_on && orient_b;
         vconn_en_b <= (state == ST_ATTACHED) && vconn_on && !orient_b;
      end
   end

   // Sink tracks the current its partner advertises on the sink line
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         snk_cur <= TCC_CUR_DEFAULT;
      else if (state == ST_SNK_ATT)
         snk_cur <= tcc_level_cur(orient_b ? lvl_b_s : lvl_a_s);
      else
         snk_cur <= TCC_CUR_DEFAULT;
   end

   // Dead-battery capability is recomputed from the filtered straps every cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         db_boot_ok <= 1'b1;
      else
         db_boot_ok <= ~(strap_s[0] & strap_s[1]);
   end

   // Termination controls; gate held low turns the untrimmed Rd off
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cc_pullup_en <= 1'b0;
         adv_current  <= TCC_CUR_DEFAULT;
         trim_rd_en   <= 1'b0;
         db_gate_oe   <= 2'b00;
      end else begin
         cc_pullup_en <= ctrl.src_role;
         adv_current  <= ctrl.adv_cur;
         trim_rd_en   <= !ctrl.src_role && ctrl.trim_rd;
         // A grounded strap is never fought by the driver
         db_gate_oe   <= {2{ctrl.trim_rd || ctrl.db_rd_off
                            || ctrl.src_role}} & ~strap_s;
      end
   end

   assign db_gate_out = 2'b00;

   // Bus handshake: one wait cycle, longer for a busy transmitter
   assign acc  = avs_read || avs_write;
   assign hold = avs_write && (avs_address == ADDR_TXDATA) && tx_busy;
   assign avs_waitrequest = acc && !ack;
   assign tx_start = ack && avs_write && (avs_address == ADDR_TXDATA)
                     && linked;
   assign linked = (state == ST_ATTACHED) || (state == ST_SNK_ATT);

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         ack <= 1'b0;
      else
         ack <= acc && !ack && !hold;
   end

   // Writable registers change at the accepting edge only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl          <= CTRL_RST;
         tx_peak_level <= TXLVL_RST;
      end else if (ack && avs_write) begin
         if (avs_address == ADDR_CTRL)
            ctrl <= tcc_ctrl_t'(avs_writedata[$bits(tcc_ctrl_t)-1:0]);
         if (avs_address == ADDR_TXLVL)
            tx_peak_level <= avs_writedata[TXLVL_W-1:0];
      end
   end

   assign status = '{term_b: term_b, term_a: term_a,
                     db_boot_ok: db_boot_ok, tx_busy: tx_busy,
                     snk_cur: snk_cur, vconn_en_b: vconn_en_b,
                     vconn_en_a: vconn_en_a, vbus_en: vbus_en,
                     orient_b: orient_b, state: 3'(state)};

   // Read data is loaded when the answer is prepared; unmapped reads 0
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         avs_readdata <= '0;
      end else if (acc && !ack) begin
         unique case (avs_address)
            ADDR_CTRL:   avs_readdata <= 32'(ctrl);
            ADDR_TXLVL:  avs_readdata <= 32'(tx_peak_level);
            ADDR_STATUS: avs_readdata <= 32'(status);
            default:     avs_readdata <= '0;
         endcase
      end
   end

   tcc_bmc_tx #(
      .HALF_CYC (HALF_UI_CYC)
   ) u_bmc (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .start   (tx_start),
      .data    (avs_writedata[TXDAT_W-1:0]),
      .busy    (tx_busy),
      .drive   (tx_drive),
      .level   (bmc_out)
   );

   // Driver sits only on the sink line and only while sending
   assign bmc_oe_a = tx_drive && !orient_b;
   assign bmc_oe_b = tx_drive && orient_b;

   AST_IDLE_NO_POWER: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_UNATT) |=> !vbus_en && !vconn_en_a && !vconn_en_b)
      else $error("Power applied while unattached");

   AST_RD_A_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_UNATT && ctrl.src_role && term_a == TCC_RD
       && term_b == TCC_OPEN) |=> ##1 vbus_en && !vconn_en_a
       && !vconn_en_b && !orient_b)
      else $error("Rd on A did not power VBUS alone");

   AST_RD_B_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_UNATT && ctrl.src_role && term_a == TCC_OPEN
       && term_b == TCC_RD) |=> ##1 vbus_en && !vconn_en_a
       && !vconn_en_b && orient_b)
      else $error("Rd on B did not power VBUS alone");

   AST_CABLE_NO_POWER: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_CABLE) |=> !vbus_en && !vconn_en_a && !vconn_en_b)
      else $error("Power applied with a cable only");

   AST_RA_A_RD_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_UNATT && ctrl.src_role && term_a == TCC_RA
       && term_b == TCC_RD) |=> ##1 vbus_en && vconn_en_a && orient_b)
      else $error("VCONN not placed on line A");

   AST_RD_A_RA_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_UNATT && ctrl.src_role && term_a == TCC_RD
       && term_b == TCC_RA) |=> ##1 vbus_en && vconn_en_b && !orient_b)
      else $error("VCONN not placed on line B");

   AST_DETACH: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_ATTACHED && ctrl.src_role
       && (orient_b ? term_b : term_a) == TCC_OPEN)
      |=> state == ST_UNATT ##1 !vbus_en)
      else $error("Detach on watched line not taken");

   AST_SNK_VBUS: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state == ST_SNK_WAIT && !ctrl.src_role && vbus_s)
      |=> state == ST_SNK_ATT)
      else $error("Sink missed VBUS attach");

   AST_ONE_DRIVER: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(bmc_oe_a && bmc_oe_b) && (tx_busy || !(bmc_oe_a || bmc_oe_b)))
      else $error("Transmit driver enable misplaced");

   AST_GATE_SRC: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ctrl.src_role && $stable(ctrl) && $stable(strap_s)
      |=> db_gate_oe == ~$past(strap_s))
      else $error("Dead-battery pulldown not held off as source");

endmodule : tcc_attach_top

/* File: tcc_partner.sv */
`timescale 1ns/1ps
// Cable and port partner: far-end terminations become comparator levels
module tcc_partner (
   input  wire tcc_pkg::tcc_term_t term_a,       // Far end on line A
   input  wire tcc_pkg::tcc_term_t term_b,       // Far end on line B
   input  wire logic [1:0]         src_lvl,      // Source pullup level
   input  wire logic               src_vbus,     // Source VBUS on
   output tcc_pkg::tcc_cmp_t       cmp_a,        // Line A comparators
   output tcc_pkg::tcc_cmp_t       cmp_b,        // Line B comparators
   output logic [1:0]              pullup_lvl_a, // Pullup seen on A
   output logic [1:0]              pullup_lvl_b, // Pullup seen on B
   output logic                    vbus_present  // VBUS valid
);
   import tcc_pkg::*;
   // Ra pulls lower than Rd, so it trips both comparators
   assign cmp_a = '{below_detach: term_a != TCC_OPEN,
                    below_cable: term_a == TCC_RA};
   assign cmp_b = '{below_detach: term_b != TCC_OPEN,
                    below_cable: term_b == TCC_RA};
   // Partner source pulls line A only; it never transmits, so it stays hi-Z
   assign pullup_lvl_a = src_lvl;
   assign pullup_lvl_b = 2'h0;
   assign vbus_present = src_vbus;
endmodule : tcc_partner

/* File: tcc_attach_top_test.sv */
`timescale 1ns/1ps
module tcc_attach_top_test;
   import tcc_pkg::*;
   localparam int ST = DEBOUNCE_CYC + 20;
   logic        sys_clk = 0, rst_n = 0, rd = 0, wr = 0, vb = 0, sga = 0;
   logic        sgb = 0, wq, pu, trim, ve, va, vcb, ob, bo, oa, obb, vp;
   logic [3:0]  adr = 4'h0, tpl;
   logic [31:0] wd = '0, rdat, q, v;
   logic [1:0]  lvl = 2'h0, goe, pla, plb;
   logic [6:0]  e, m;
   logic [7:0]  got;
   tcc_term_t   ta = TCC_OPEN, tb = TCC_OPEN;
   tcc_cmp_t    ca, cb;
   tcc_cur_t    acur;
   int          err_count = 0, total_checks = 0, seed = 2, cyc = 0, k, n;
   // Termination table and expected STATUS[6:0] per pair
   tcc_term_t   tab_a [9] = '{TCC_OPEN, TCC_RD, TCC_OPEN, TCC_RA, TCC_OPEN,
                              TCC_RA, TCC_RD, TCC_RD, TCC_RA};
   tcc_term_t   tab_b [9] = '{TCC_OPEN, TCC_OPEN, TCC_RD, TCC_OPEN, TCC_RA,
                              TCC_RD, TCC_RA, TCC_RD, TCC_RA};
   logic [6:0]  exp_st [9] = '{7'h00, 7'h12, 7'h1a, 7'h01, 7'h01, 7'h3a,
                               7'h52, 7'h03, 7'h04};
   tcc_attach_top i_tcc_attach_top (
      .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
      .avs_waitrequest(wq), .cmp_a(ca), .cmp_b(cb), .pullup_lvl_a(pla),
      .pullup_lvl_b(plb), .vbus_present(vp), .strap_gnd_a(sga),
      .strap_gnd_b(sgb), .cc_pullup_en(pu), .adv_current(acur),
      .trim_rd_en(trim), .db_gate_out(), .db_gate_oe(goe), .vbus_en(ve),
      .vconn_en_a(va), .vconn_en_b(vcb), .orient_b(ob),
      .tx_peak_level(tpl), .bmc_out(bo), .bmc_oe_a(oa), .bmc_oe_b(obb));
   tcc_partner i_tcc_partner (
      .term_a(ta), .term_b(tb), .src_lvl(lvl), .src_vbus(vb), .cmp_a(ca),
      .cmp_b(cb), .pullup_lvl_a(pla), .pullup_lvl_b(plb), .vbus_present(vp));
   always #2.5 sys_clk = ~sys_clk;
   // Hang guard, well above the roughly 50k cycles the run needs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string s, input logic [31:0] x, y);
      total_checks++;
      if (y !== x) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", s, x, y);
      end
   endtask : chk
   task automatic waitc(input int c);
      repeat (c) @(posedge sys_clk);
   endtask : waitc
   // Avalon cycle; waitrequest and read data taken at the deciding edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge sys_clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do begin @(posedge sys_clk); t++; end while (wq !== 1'b0 && t < 5000);
      if (wq !== 1'b0) err_count++;
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   initial begin
      waitc(8);
      rst_n <= 1'b1;
      waitc(2);
      chk("gate_oe", 0, goe);
      chk("trim_rd_en", 0, trim);
      bus(0, ADDR_TXLVL, 0); chk("txlvl", 32'(TXLVL_RST), q);
      bus(0, 4'h2, 0); chk("unmapped", 0, q);
      v = $random(seed);
      bus(1, ADDR_TXLVL, v);
      bus(0, ADDR_TXLVL, 0); chk("txlvl", v[3:0], q);
      chk("tx_peak_level", v[3:0], tpl);
      // Source role at each advertised current
      for (int c = 0; c < 3; c++) begin
         bus(1, ADDR_CTRL, 32'(c * 4 + 2));
         waitc(3);
         chk("adv_current", c, acur);
         chk("pullup", 1, pu);
         chk("gate_oe", 3, goe);
      end
      // Every termination pair, returning to open between them
      for (int i = 0; i < 18; i++) begin
         k = i[0] ? 0 : i / 2;
         ta <= tab_a[k];
         tb <= tab_b[k];
         waitc(ST);
         bus(0, ADDR_STATUS, 0);
         e = exp_st[k];
         m = (e[2:0] == 3'h2) ? 7'h7f : (e[2:0] < 3'h2) ? 7'h77 : 7'h07;
         chk("status", e & m, q[6:0] & m);
         chk("terms", {tab_b[k], tab_a[k]}, q[14:11]);
         if (e[2:0] < 3'h3) chk("vbus_en", e[4], ve);
         if (e[2:0] == 3'h2) chk("orient_b", e[3], ob);
      end
      // Cable on A first, then a sink on B behind it
      ta <= TCC_RA;
      waitc(ST);
      tb <= TCC_RD;
      waitc(ST);
      bus(0, ADDR_STATUS, 0);
      chk("cable_then_sink", 7'h3a, q[6:0]);
      // One byte on line A, decoded at the middle of each half cell
      ta <= TCC_RD;
      tb <= TCC_OPEN;
      waitc(ST);
      v = $random(seed);
      bus(1, ADDR_TXDATA, v[7:0]);
      n = 0;
      while (oa !== 1'b1 && n < 20) begin @(negedge sys_clk); n++; end
      chk("bmc_oe_a", 1, oa);
      repeat (HALF_UI_CYC / 2) @(negedge sys_clk);
      for (int b = 0; b < 8; b++) begin
         got[b] = bo;
         repeat (HALF_UI_CYC) @(negedge sys_clk);
         got[b] = got[b] ^ bo;
         chk("bmc_oe_b", 0, obb);
         repeat (HALF_UI_CYC) @(negedge sys_clk);
      end
      chk("bmc_byte", v[7:0], got);
      n = 0;
      while (oa !== 1'b0 && n < 1000) begin @(negedge sys_clk); n++; end
      chk("bmc_oe_a", 0, oa);
      // Sink role with a trimmed pulldown and a random source level
      bus(1, ADDR_CTRL, 1);
      ta <= TCC_OPEN;
      waitc(3);
      chk("trim_rd_en", 1, trim);
      chk("pullup", 0, pu);
      v = $random(seed);
      lvl <= 2'(1 + (v & 32'h7fff) % 3);
      vb <= 1'b1;
      waitc(ST);
      bus(0, ADDR_STATUS, 0);
      chk("snk_state", 6, q[2:0]);
      chk("snk_cur", lvl - 2'h1, q[8:7]);
      vb <= 1'b0;
      sga <= 1'b1;
      sgb <= 1'b1;
      waitc(ST);
      bus(0, ADDR_STATUS, 0);
      chk("snk_state", 5, q[2:0]);
      chk("db_boot_ok", 0, q[10]);
      chk("gate_oe", 0, goe);
      print_verdict();
   end
endmodule : tcc_attach_top_test
